//--- hdl/exec_pkg.sv
/*
  constants, opcodes, register indices and state codes for the move, shift and
  frame-link execution datapath.
  assumes a 16-bit register file of sixteen words, index 0 being the null register.
*/
package exec_pkg;
  // opcodes
  localparam logic [7:0] OP_MOV_RR_W = 8'h02;
  localparam logic [7:0] OP_MOV_RR_B = 8'h03;
  localparam logic [7:0] OP_MOV_RI_W = 8'h04;
  localparam logic [7:0] OP_MOV_RI_B = 8'h05;
  localparam logic [7:0] OP_MOV_RP_W = 8'h06;
  localparam logic [7:0] OP_MOV_RP_B = 8'h07;
  localparam logic [7:0] OP_MOV_IR_B = 8'h0A;
  localparam logic [7:0] OP_MOV_IR_W = 8'h0B;
  localparam logic [7:0] OP_MOV_PR_W = 8'h12;
  localparam logic [7:0] OP_MOV_PR_B = 8'h13;
  localparam logic [7:0] OP_MOV_PI_W = 8'h14;
  localparam logic [7:0] OP_MOV_PI_B = 8'h15;
  localparam logic [7:0] OP_MOV_PP_W = 8'h16;
  localparam logic [7:0] OP_MOV_PP_B = 8'h17;
  localparam logic [7:0] OP_MOV_PD_W = 8'h18;
  localparam logic [7:0] OP_MOV_PD_B = 8'h19;
  localparam logic [7:0] OP_MOV_KR_W = 8'h1A;
  localparam logic [7:0] OP_MOV_KR_B = 8'h1B;
  localparam logic [7:0] OP_MOV_DR_W = 8'h22;
  localparam logic [7:0] OP_MOV_DR_B = 8'h23;
  localparam logic [7:0] OP_QUICK = 8'h80;
  localparam logic [7:0] OP_LSR_IMM = 8'hBC;
  localparam logic [7:0] OP_LONG_LOGICAL_SHIFT_RIGHT_OP_IMM = 8'hBD;
  localparam logic [7:0] OP_LSR_REG = 8'hBE;
  localparam logic [7:0] OP_LONG_LOGICAL_SHIFT_RIGHT_OP_REG = 8'hBF;
  localparam logic [7:0] OP_LINK = 8'hF7;
  // register indices
  localparam logic [3:0] REG_NULL = 4'h0;
  localparam logic [3:0] REG_HIGH = 4'hD;
  localparam logic [3:0] REG_FP = 4'hE;
  localparam logic [3:0] REG_SP = 4'hF;
  // operand addressing modes
  localparam logic [2:0] M_NONE = 3'h0;
  localparam logic [2:0] M_REG = 3'h1;
  localparam logic [2:0] M_IND = 3'h2;
  localparam logic [2:0] M_POST = 3'h3;
  localparam logic [2:0] M_DISP = 3'h4;
  localparam logic [2:0] M_IMM = 3'h5;
  // steps and counts
  localparam logic [15:0] STEP_BYTE = 16'h0001;
  localparam logic [15:0] STEP_WORD = 16'h0002;
  localparam logic [15:0] LINK_STEP = 16'h0002;
  localparam logic [4:0] CNT_FULL = 5'h10;
  localparam logic [4:0] CNT_ONE = 5'h01;
  localparam logic [4:0] CNT_ZERO = 5'h00;
  // sequencer states
  typedef enum logic [5:0] {
    ST_IDLE = 6'h01,
    ST_LINK = 6'h02,
    ST_SHIFT = 6'h04,
    ST_READ = 6'h08,
    ST_DEST = 6'h10,
    ST_WRITE = 6'h20
  } exec_state_t;
endpackage

//--- hdl/shift_step.sv
/*
  one-bit logical right shift step over a word or a high:low longword pair.
  assumes the caller repeats it once per position and keeps the count itself.
*/
`timescale 1ns/1ps
module shift_step (
  // operand
  input wire logic long_i,
  input wire logic [15:0] hi_i,
  input wire logic [15:0] lo_i,
  // result
  output logic [15:0] hi_o,
  output logic [15:0] lo_o,
  output logic out_bit_o
);
  // zero enters at the top; in long form the high word feeds the low word
  always_comb
  begin
    hi_o = long_i ? {1'b0, hi_i[15:1]} : 16'h0000;
    lo_o = {long_i ? hi_i[0] : 1'b0, lo_i[15:1]};
    out_bit_o = lo_i[0];
  end
endmodule

//--- hdl/move_shift_link_exec.sv
/*
  execution sequencer for frame link, logical right shift, data move and quick load.
  assumes the decoder presents one instruction with its extension word on start_i
  while busy_o is low, and a memory bus that answers each request with one ack.
*/
`timescale 1ns/1ps
module move_shift_link_exec (
  // clock and reset
  input wire logic clk_i,
  input wire logic rst_i,
  // instruction
  input wire logic start_i,
  input wire logic [7:0] opcode_i,
  input wire logic [3:0] src_sel_i,
  input wire logic [3:0] dst_sel_i,
  input wire logic [15:0] ext_i,
  output logic busy_o,
  output logic done_o,
  // status flags
  output logic zero_o,
  output logic neg_o,
  output logic carry_o,
  output logic ovf_o,
  // memory bus
  output logic mem_req_o,
  output logic mem_we_o,
  output logic mem_byte_o,
  output logic [15:0] mem_addr_o,
  output logic [15:0] mem_wdata_o,
  input wire logic mem_ack_i,
  input wire logic [15:0] mem_rdata_i,
  // register observation
  input wire logic [3:0] obs_sel_i,
  output logic [15:0] obs_data_o
);
  typedef struct packed {
    exec_pkg::exec_state_t st;
    logic [15:0][15:0] regs;
    logic zf;
    logic nf;
    logic cf;
    logic vf;
    logic busy;
    logic done;
    logic req;
    logic we;
    logic byte_sz;
    logic [15:0] addr;
    logic [15:0] wdata;
    logic [15:0] obs;
    logic [7:0] op;
    logic [3:0] src;
    logic [3:0] dst;
    logic [15:0] ext;
    logic [2:0] sm;
    logic [2:0] dm;
    logic [4:0] cnt;
    logic [15:0] base;
    logic [15:0] data;
  } exec_regs_t;

  exec_regs_t s_r;
  exec_regs_t s_nxt;
  logic [15:0] sh_hi;
  logic [15:0] sh_lo;
  logic sh_bit;
  logic long_op;
  logic same_post;
  logic [15:0] step;

  // source and destination modes of each move opcode
  function automatic logic [5:0] mov_modes(input logic [7:0] op);
    case (op)
      exec_pkg::OP_MOV_RR_W, exec_pkg::OP_MOV_RR_B: mov_modes = {exec_pkg::M_REG, exec_pkg::M_REG};
      exec_pkg::OP_MOV_RI_W, exec_pkg::OP_MOV_RI_B: mov_modes = {exec_pkg::M_REG, exec_pkg::M_IND};
      exec_pkg::OP_MOV_RP_W, exec_pkg::OP_MOV_RP_B: mov_modes = {exec_pkg::M_REG, exec_pkg::M_POST};
      exec_pkg::OP_MOV_IR_W, exec_pkg::OP_MOV_IR_B: mov_modes = {exec_pkg::M_IND, exec_pkg::M_REG};
      exec_pkg::OP_MOV_PR_W, exec_pkg::OP_MOV_PR_B: mov_modes = {exec_pkg::M_POST, exec_pkg::M_REG};
      exec_pkg::OP_MOV_PI_W, exec_pkg::OP_MOV_PI_B: mov_modes = {exec_pkg::M_POST, exec_pkg::M_IND};
      exec_pkg::OP_MOV_PP_W, exec_pkg::OP_MOV_PP_B: mov_modes = {exec_pkg::M_POST, exec_pkg::M_POST};
      exec_pkg::OP_MOV_PD_W, exec_pkg::OP_MOV_PD_B: mov_modes = {exec_pkg::M_POST, exec_pkg::M_DISP};
      exec_pkg::OP_MOV_KR_W, exec_pkg::OP_MOV_KR_B: mov_modes = {exec_pkg::M_IMM, exec_pkg::M_REG};
      exec_pkg::OP_MOV_DR_W, exec_pkg::OP_MOV_DR_B: mov_modes = {exec_pkg::M_DISP, exec_pkg::M_REG};
      default: mov_modes = {exec_pkg::M_NONE, exec_pkg::M_NONE};
    endcase
  endfunction

  // byte form: odd opcodes, except the indirect-to-register pair which is swapped
  function automatic logic is_byte(input logic [7:0] op);
    if (op == exec_pkg::OP_MOV_IR_B)
      is_byte = 1'b1;
    else if (op == exec_pkg::OP_MOV_IR_W)
      is_byte = 1'b0;
    else
      is_byte = op[0];
  endfunction

  // keep only the low byte for byte moves
  function automatic logic [15:0] size_mask(input logic [15:0] v, input logic b);
    size_mask = b ? {8'h00, v[7:0]} : v;
  endfunction

  // the null register ignores writes, so it always reads back zero
  function automatic logic [15:0][15:0] reg_put(input logic [15:0][15:0] r,
                                                input logic [3:0] i, input logic [15:0] v);
    reg_put = r;
    if (i != exec_pkg::REG_NULL)
      reg_put[i] = v;
  endfunction

  shift_step u_shift (
    .long_i(long_op),
    .hi_i(s_r.base),
    .lo_i(s_r.data),
    .hi_o(sh_hi),
    .lo_o(sh_lo),
    .out_bit_o(sh_bit)
  );

  // operation attributes shared by several states
  assign long_op = (s_r.op == exec_pkg::OP_LONG_LOGICAL_SHIFT_RIGHT_OP_IMM) || (s_r.op == exec_pkg::OP_LONG_LOGICAL_SHIFT_RIGHT_OP_REG);
  assign same_post = (s_r.sm == exec_pkg::M_POST) && (s_r.src == s_r.dst);
  assign step = s_r.byte_sz ? exec_pkg::STEP_BYTE : exec_pkg::STEP_WORD;

  // sequencer: one copy of the state, filled on every path
  always_comb
  begin
    s_nxt = s_r;
    s_nxt.done = 1'b0;
    s_nxt.obs = s_r.regs[obs_sel_i];
    case (s_r.st)
      exec_pkg::ST_IDLE:
      begin
        if (start_i)
        begin
          s_nxt.op = opcode_i;
          s_nxt.src = src_sel_i;
          s_nxt.dst = dst_sel_i;
          s_nxt.ext = ext_i;
          s_nxt.busy = 1'b1;
          s_nxt.byte_sz = is_byte(opcode_i);
          {s_nxt.sm, s_nxt.dm} = mov_modes(opcode_i);
          s_nxt.base = s_r.regs[dst_sel_i];
          case (opcode_i)
            exec_pkg::OP_QUICK:
            begin
              // single word, single cycle; carry kept
              s_nxt.regs = reg_put(s_r.regs, dst_sel_i, {12'h000, src_sel_i});
              s_nxt.zf = (src_sel_i == 4'h0);
              s_nxt.nf = 1'b0;
              s_nxt.vf = 1'b0;
              s_nxt.done = 1'b1;
              s_nxt.busy = 1'b0;
            end
            exec_pkg::OP_LINK:
            begin
              // push the frame pointer at the stack pointer as a word
              s_nxt.req = 1'b1;
              s_nxt.we = 1'b1;
              s_nxt.byte_sz = 1'b0;
              s_nxt.addr = s_r.regs[exec_pkg::REG_SP];
              s_nxt.wdata = s_r.regs[exec_pkg::REG_FP];
              s_nxt.st = exec_pkg::ST_LINK;
            end
            exec_pkg::OP_LSR_IMM, exec_pkg::OP_LONG_LOGICAL_SHIFT_RIGHT_OP_IMM, exec_pkg::OP_LSR_REG,
            exec_pkg::OP_LONG_LOGICAL_SHIFT_RIGHT_OP_REG:
            begin
              s_nxt.byte_sz = 1'b0;
              s_nxt.data = s_r.regs[dst_sel_i];
              // high word from the fixed register D (REG_HIGH) whatever the destination; naming it twice is undefined
              s_nxt.base = opcode_i[0] ? s_r.regs[exec_pkg::REG_HIGH] : 16'h0000;
              if (!opcode_i[1])
                s_nxt.cnt = (src_sel_i == 4'h0) ? exec_pkg::CNT_FULL : {1'b0, src_sel_i};
              else
                s_nxt.cnt = {1'b0, s_r.regs[src_sel_i][3:0]};
              if (opcode_i[1] && (s_r.regs[src_sel_i][3:0] == 4'h0))
                s_nxt.cf = 1'b0;
              s_nxt.st = exec_pkg::ST_SHIFT;
            end
            default:
            begin
              case (s_nxt.sm)
                exec_pkg::M_REG:
                begin
                  s_nxt.data = size_mask(s_r.regs[src_sel_i], is_byte(opcode_i));
                  s_nxt.st = exec_pkg::ST_DEST;
                end
                exec_pkg::M_IMM:
                begin
                  s_nxt.data = size_mask(ext_i, is_byte(opcode_i));
                  s_nxt.st = exec_pkg::ST_DEST;
                end
                exec_pkg::M_IND, exec_pkg::M_POST:
                begin
                  s_nxt.req = 1'b1;
                  s_nxt.we = 1'b0;
                  s_nxt.addr = s_r.regs[src_sel_i];
                  s_nxt.st = exec_pkg::ST_READ;
                end
                exec_pkg::M_DISP:
                begin
                  s_nxt.req = 1'b1;
                  s_nxt.we = 1'b0;
                  s_nxt.addr = ext_i + s_r.regs[src_sel_i];
                  s_nxt.st = exec_pkg::ST_READ;
                end
                default:
                begin
                  // unknown opcode retires with no effect
                  s_nxt.done = 1'b1;
                  s_nxt.busy = 1'b0;
                end
              endcase
            end
          endcase
        end
      end
      exec_pkg::ST_LINK:
      begin
        if (mem_ack_i)
        begin
          // flags are never touched on this path
          s_nxt.req = 1'b0;
          s_nxt.we = 1'b0;
          s_nxt.regs = reg_put(s_r.regs, exec_pkg::REG_FP, s_r.regs[exec_pkg::REG_SP]);
          // displacement 0..255 words, doubled so the pointer stays even
          s_nxt.regs[exec_pkg::REG_SP] = s_r.regs[exec_pkg::REG_SP] + exec_pkg::LINK_STEP
                                         + {7'h00, s_r.ext[7:0], 1'b0};
          s_nxt.done = 1'b1;
          s_nxt.busy = 1'b0;
          s_nxt.st = exec_pkg::ST_IDLE;
        end
      end
      exec_pkg::ST_SHIFT:
      begin
        // one position per cycle keeps the shifter small at the cost of latency
        if (s_r.cnt != exec_pkg::CNT_ZERO)
        begin
          s_nxt.base = sh_hi;
          s_nxt.data = sh_lo;
          s_nxt.cf = sh_bit;
          s_nxt.cnt = s_r.cnt - exec_pkg::CNT_ONE;
        end
        else
        begin
          if (long_op)
            s_nxt.regs = reg_put(s_r.regs, exec_pkg::REG_HIGH, s_r.base);
          s_nxt.regs = reg_put(s_nxt.regs, s_r.dst, s_r.data);
          s_nxt.zf = long_op ? ({s_r.base, s_r.data} == 32'h0000_0000)
                             : (s_r.data == 16'h0000);
          s_nxt.nf = long_op ? s_r.base[15] : s_r.data[15];
          s_nxt.vf = 1'b0;
          s_nxt.done = 1'b1;
          s_nxt.busy = 1'b0;
          s_nxt.st = exec_pkg::ST_IDLE;
        end
      end
      exec_pkg::ST_READ:
      begin
        if (mem_ack_i)
        begin
          s_nxt.req = 1'b0;
          s_nxt.data = size_mask(mem_rdata_i, s_r.byte_sz);
          if (s_r.sm == exec_pkg::M_POST)
            s_nxt.regs = reg_put(s_r.regs, s_r.src, s_r.regs[s_r.src] + step);
          s_nxt.st = exec_pkg::ST_DEST;
        end
      end
      exec_pkg::ST_DEST:
      begin
        s_nxt.zf = (s_r.data == 16'h0000);
        s_nxt.nf = s_r.byte_sz ? s_r.data[7] : s_r.data[15];
        s_nxt.vf = 1'b0;
        if (s_r.dm == exec_pkg::M_REG)
        begin
          // same-register load: the loaded value plus one step wins over the pointer
          s_nxt.regs = reg_put(s_r.regs, s_r.dst, same_post ? s_r.data + step : s_r.data);
          s_nxt.done = 1'b1;
          s_nxt.busy = 1'b0;
          s_nxt.st = exec_pkg::ST_IDLE;
        end
        else
        begin
          s_nxt.req = 1'b1;
          s_nxt.we = 1'b1;
          s_nxt.wdata = s_r.data;
          // indirect and indexed targets use the pointer as it was before the read
          case (s_r.dm)
            exec_pkg::M_POST: s_nxt.addr = s_r.regs[s_r.dst];
            exec_pkg::M_IND: s_nxt.addr = s_r.base;
            default: s_nxt.addr = s_r.ext + s_r.base;
          endcase
          s_nxt.st = exec_pkg::ST_WRITE;
        end
      end
      exec_pkg::ST_WRITE:
      begin
        if (mem_ack_i)
        begin
          s_nxt.req = 1'b0;
          s_nxt.we = 1'b0;
          // a shared pointer was already stepped once by the read, so this is the second
          if (s_r.dm == exec_pkg::M_POST)
            s_nxt.regs = reg_put(s_r.regs, s_r.dst, s_r.regs[s_r.dst] + step);
          s_nxt.done = 1'b1;
          s_nxt.busy = 1'b0;
          s_nxt.st = exec_pkg::ST_IDLE;
        end
      end
      default:
      begin
        s_nxt.st = exec_pkg::ST_IDLE;
        s_nxt.req = 1'b0;
        s_nxt.busy = 1'b0;
      end
    endcase
  end

  // state register
  always_ff @(posedge clk_i or posedge rst_i)
  begin
    if (rst_i)
    begin
      s_r <= '0;
      s_r.st <= exec_pkg::ST_IDLE;
    end
    else
    begin
      s_r <= s_nxt;
    end
  end

  // outputs come straight from the state flops
  assign busy_o = s_r.busy;
  assign done_o = s_r.done;
  assign zero_o = s_r.zf;
  assign neg_o = s_r.nf;
  assign carry_o = s_r.cf;
  assign ovf_o = s_r.vf;
  assign mem_req_o = s_r.req;
  assign mem_we_o = s_r.we;
  assign mem_byte_o = s_r.byte_sz;
  assign mem_addr_o = s_r.addr;
  assign mem_wdata_o = s_r.wdata;
  assign obs_data_o = s_r.obs;

  default clocking cb @(posedge clk_i); endclocking
  default disable iff (rst_i);

  sequence s_link_start;
    (s_r.st == exec_pkg::ST_IDLE) && start_i && (opcode_i == exec_pkg::OP_LINK);
  endsequence
  sequence s_link_ack;
    (s_r.st == exec_pkg::ST_LINK) && mem_ack_i;
  endsequence
  sequence s_quick_start;
    (s_r.st == exec_pkg::ST_IDLE) && start_i && (opcode_i == exec_pkg::OP_QUICK);
  endsequence

  property p_link_push;
    s_link_start |=> mem_req_o && mem_we_o && !mem_byte_o
      && (mem_addr_o == $past(s_r.regs[exec_pkg::REG_SP]))
      && (mem_wdata_o == $past(s_r.regs[exec_pkg::REG_FP]));
  endproperty
  a_link_push: assert property (p_link_push) else $error("link push wrong");

  property p_link_sp;
    s_link_ack |=> (s_r.regs[exec_pkg::REG_SP] == $past(s_r.regs[exec_pkg::REG_SP]
      + exec_pkg::LINK_STEP + {7'h00, s_r.ext[7:0], 1'b0}))
      && (s_r.regs[exec_pkg::REG_FP] == $past(s_r.regs[exec_pkg::REG_SP])) && done_o;
  endproperty
  a_link_sp: assert property (p_link_sp) else $error("link pointer update wrong");

  property p_link_flags;
    (s_r.st == exec_pkg::ST_LINK) |=> $stable({zero_o, neg_o, carry_o, ovf_o});
  endproperty
  a_link_flags: assert property (p_link_flags) else $error("link changed flags");

  property p_shift_step;
    (s_r.st == exec_pkg::ST_SHIFT) && (s_r.cnt != exec_pkg::CNT_ZERO)
      |=> (s_r.st == exec_pkg::ST_SHIFT) && (s_r.cnt == $past(s_r.cnt) - exec_pkg::CNT_ONE)
          && (carry_o == $past(s_r.data[0]));
  endproperty
  a_shift_step: assert property (p_shift_step) else $error("shift step wrong");

  property p_imm_zero_count;
    (s_r.st == exec_pkg::ST_IDLE) && start_i && (opcode_i == exec_pkg::OP_LSR_IMM)
      && (src_sel_i == 4'h0) |=> (s_r.cnt == exec_pkg::CNT_FULL);
  endproperty
  a_imm_zero_count: assert property (p_imm_zero_count) else $error("zero count not 16");

  property p_shift_end;
    (s_r.st == exec_pkg::ST_SHIFT) && (s_r.cnt == exec_pkg::CNT_ZERO) && !long_op
      |=> done_o && !ovf_o && (neg_o == $past(s_r.data[15]))
          && (zero_o == ($past(s_r.data) == 16'h0000));
  endproperty
  a_shift_end: assert property (p_shift_end) else $error("shift flags wrong");

  property p_byte_load;
    (s_r.st == exec_pkg::ST_DEST) && (s_r.dm == exec_pkg::M_REG) && s_r.byte_sz && !same_post
      |=> (s_r.regs[s_r.dst][15:8] == 8'h00);
  endproperty
  a_byte_load: assert property (p_byte_load) else $error("byte load high not clear");

  property p_move_carry;
    (s_r.st == exec_pkg::ST_DEST) |=> $stable(carry_o) && !ovf_o;
  endproperty
  a_move_carry: assert property (p_move_carry) else $error("move flags wrong");

  property p_quick;
    s_quick_start |=> done_o && !busy_o && !neg_o && !ovf_o && $stable(carry_o)
      && (zero_o == (s_r.src == 4'h0));
  endproperty
  a_quick: assert property (p_quick) else $error("quick load wrong");

  property p_quick_val;
    s_quick_start ##1 (s_r.dst != exec_pkg::REG_NULL)
      |-> (s_r.regs[s_r.dst] == {12'h000, s_r.src});
  endproperty
  a_quick_val: assert property (p_quick_val) else $error("quick value wrong");
endmodule

//--- bench/mem_partner.sv
/*
  memory bus partner: byte array answering each request with one ack after wait_i cycles.
  assumes one request at a time, held by the core until the ack is seen.
*/
`timescale 1ns/1ps
module mem_partner (
  // clock and reset
  input wire logic clk_i,
  input wire logic rst_i,
  // bus from the core
  input wire logic req_i,
  input wire logic we_i,
  input wire logic byte_i,
  input wire logic [15:0] addr_i,
  input wire logic [15:0] wdata_i,
  input wire logic [1:0] wait_i,
  output logic ack_o,
  output logic [15:0] rdata_o
);
  logic [7:0] mem [0:65535];
  logic [1:0] cnt;
  // read data flips when idle and after the ack, and holds through wait cycles, so stale data never passes for valid
  always @(posedge clk_i or posedge rst_i)
  begin
    if (rst_i)
    begin
      ack_o <= 1'b0;
      cnt <= 2'h0;
      rdata_o <= 16'h0000;
    end
    else if (req_i && !ack_o && cnt == wait_i)
    begin
      ack_o <= 1'b1;
      cnt <= 2'h0;
      rdata_o <= byte_i ? {8'h00, mem[addr_i]} : {mem[addr_i + 16'h0001], mem[addr_i]};
      if (we_i)
      begin
        mem[addr_i] <= wdata_i[7:0];
        if (!byte_i)
          mem[addr_i + 16'h0001] <= wdata_i[15:8];
      end
    end
    else if (req_i && !ack_o)
      cnt <= cnt + 2'h1;
    else
    begin
      ack_o <= 1'b0;
      rdata_o <= ~rdata_o;
    end
  end
endmodule

//--- bench/cpu_move_shift_link_exec_tb_top.sv
/*
  self-checking bench for the move, shift and frame-link sequencer.
  assumes the memory partner model and the register observe port.
*/
`timescale 1ns/1ps
module cpu_move_shift_link_exec_tb_top;
  logic clk_i = 1'b0;
  logic rst_i = 1'b1;
  logic start_i = 1'b0;
  logic [7:0] opcode_i = 8'h00;
  logic [3:0] src_sel_i = 4'h0;
  logic [3:0] dst_sel_i = 4'h0;
  logic [3:0] obs_sel_i = 4'h0;
  logic [15:0] ext_i = 16'h0000;
  logic [1:0] wait_i = 2'h0;
  logic busy_o, done_o, zero_o, neg_o, carry_o, ovf_o, mem_req_o, mem_we_o, mem_byte_o;
  logic mem_ack_i;
  logic [15:0] mem_addr_o, mem_wdata_o, mem_rdata_i, obs_data_o, a, d, v;
  logic [15:0] rf [16];
  logic [3:0] fl_q [$];
  logic [3:0] fl;
  logic [32:0] t;
  int err_count = 0;
  int total_checks = 0;
  int cyc, cq, amt, sz, o;
  always #10 clk_i = ~clk_i;
  move_shift_link_exec i_dut (.clk_i(clk_i), .rst_i(rst_i), .start_i(start_i),
    .opcode_i(opcode_i), .src_sel_i(src_sel_i), .dst_sel_i(dst_sel_i), .ext_i(ext_i),
    .busy_o(busy_o), .done_o(done_o), .zero_o(zero_o), .neg_o(neg_o), .carry_o(carry_o),
    .ovf_o(ovf_o), .mem_req_o(mem_req_o), .mem_we_o(mem_we_o), .mem_byte_o(mem_byte_o),
    .mem_addr_o(mem_addr_o), .mem_wdata_o(mem_wdata_o), .mem_ack_i(mem_ack_i),
    .mem_rdata_i(mem_rdata_i), .obs_sel_i(obs_sel_i), .obs_data_o(obs_data_o));
  mem_partner i_mem (.clk_i(clk_i), .rst_i(rst_i), .req_i(mem_req_o), .we_i(mem_we_o),
    .byte_i(mem_byte_o), .addr_i(mem_addr_o), .wdata_i(mem_wdata_o), .wait_i(wait_i),
    .ack_o(mem_ack_i), .rdata_o(mem_rdata_i));
  task automatic bad(input string m);
    $display("BAD t=%0t %s", $time, m);
    err_count++;
  endtask
  task automatic chk_val(input logic [15:0] g, input logic [15:0] e, input string m);
    total_checks++;
    if (g !== e)
      bad(m);
  endtask
  task automatic chk_fl(input logic [3:0] e);
    total_checks++;
    if ({zero_o, neg_o, carry_o, ovf_o} !== e)
      bad("flags");
  endtask
  task automatic give_verdict;
    $display("errors %0d checks %0d", err_count, total_checks);
    if (err_count == 0 && total_checks > 0)
      $display("ALL CHECKS OK");
    else
      $display("CHECKS NOT OK");
    $finish;
  endtask
  // one instruction; cyc counts edges from the taking edge to the retire pulse
  task automatic exec(input logic [7:0] op, input logic [3:0] s, input logic [3:0] r,
    input logic [15:0] x, input logic [3:0] e);
    fl = e;
    fl_q.push_back(e);
    @(posedge clk_i);
    start_i <= 1'b1;
    opcode_i <= op;
    src_sel_i <= s;
    dst_sel_i <= r;
    ext_i <= x;
    @(posedge clk_i);
    start_i <= 1'b0;
    cyc = 0;
    do
    begin
      @(posedge clk_i);
      cyc++;
    end
    while (done_o !== 1'b1 && cyc < 600);
    if (cyc >= 600)
    begin
      bad("timeout");
      give_verdict();
    end
  endtask
  // register load through the two-word immediate move, carry kept
  task automatic ld(input logic [3:0] r, input logic [15:0] x);
    exec(8'h1A, 4'h0, r, x, {x == 16'h0000, x[15], fl[1], 1'b0});
    rf[r] = x;
  endtask
  task automatic chk_reg(input logic [3:0] r);
    @(posedge clk_i);
    obs_sel_i <= r;
    repeat (2) @(posedge clk_i);
    chk_val(obs_data_o, rf[r], "register");
  endtask
  // flags are judged at the edge where the retire pulse is seen
  always @(posedge clk_i)
    if (done_o === 1'b1)
    begin
      if (fl_q.size() == 0)
        bad("stray done");
      else
      begin
        chk_fl(fl_q.pop_front());
        chk_val({15'h0000, busy_o}, 16'h0000, "busy at retire");
      end
    end
  initial
  begin
    v = 16'($urandom(32'h4E46));
    fl = 4'h0;
    repeat (5) @(posedge clk_i);
    rst_i <= 1'b0;
    // quick load of every immediate value
    for (int i = 0; i < 16; i++)
    begin
      exec(8'h80, 4'(i), 4'h1, 16'h0000, {i == 0, 1'b0, fl[1], 1'b0});
      cq = cyc;
      rf[1] = 16'(i);
      chk_reg(4'h1);
    end
    ld(4'h2, 16'hFFFF);
    chk_val(16'(cyc), 16'(cq + 1), "imm16 time");
    // every count in the four shift forms; bit 0 of t is the last bit out
    for (int k = 0; k < 64; k++)
    begin
      ld(4'h3, 16'($urandom));
      ld(4'hD, 16'($urandom));
      ld(4'h4, {12'($urandom), 4'(k >> 2)});
      amt = (k[1] || (k >> 2) != 0) ? (k >> 2) : 16;
      t = {k[0] ? rf[13] : 16'h0000, rf[3], 1'b0} >> amt;
      v = k[0] ? {15'(t[32:17] != 0), t[32]} : {15'(0), t[16]};
      exec(8'hBC + 8'(k[1:0]), k[1] ? 4'h4 : 4'(k >> 2), 4'h3, 16'h0000,
        {t[16:1] == 0 && v[1] == 1'b0, v[0], t[0], 1'b0});
      rf[3] = t[16:1];
      if (k[0])
        rf[13] = t[32:17];
      chk_reg(4'h3);
      chk_reg(4'hD);
      if (k[1:0] == 2'b00)
        chk_val(16'(cyc), 16'(cq + amt + 1), "shift time");
    end
    // word and byte register moves with awkward low bytes
    for (int j = 0; j < 4; j++)
    begin
      v = j == 0 ? 16'hAB00 : j == 1 ? 16'h0080 : 16'($urandom);
      ld(4'h6, v);
      exec(8'h02, 4'h6, 4'h7, 16'h0000, {v == 16'h0000, v[15], fl[1], 1'b0});
      rf[7] = v;
      chk_reg(4'h7);
      exec(8'h03, 4'h6, 4'h8, 16'h0000, {v[7:0] == 8'h00, v[7], fl[1], 1'b0});
      rf[8] = {8'h00, v[7:0]};
      chk_reg(4'h8);
    end
    // frame link with the smallest, largest and a random displacement
    for (int j = 0; j < 3; j++)
    begin
      wait_i <= 2'($urandom);
      d = j == 0 ? 16'h0000 : j == 1 ? 16'h00FF : {8'h00, 8'($urandom)};
      a = {15'($urandom), 1'b0};
      v = 16'($urandom);
      ld(4'hF, a);
      ld(4'hE, v);
      exec(8'hF7, 4'h0, 4'h0, d, fl);
      rf[14] = a;
      rf[15] = a + 16'h0002 + {d[14:0], 1'b0};
      chk_val({i_mem.mem[a + 16'h0001], i_mem.mem[a]}, v, "pushed");
      chk_reg(4'hE);
      chk_reg(4'hF);
    end
    // post-increment source into the same pointer register, slow and prompt memory
    for (int j = 0; j < 6; j++)
    begin
      wait_i <= 2'($urandom);
      a = {14'($urandom), 2'b00};
      for (int b = 0; b < 4; b++)
        i_mem.mem[a + 16'(b)] = 8'($urandom);
      sz = j[0] ? 1 : 2;
      d = j[0] ? {8'h00, i_mem.mem[a]} : {i_mem.mem[a + 16'h0001], i_mem.mem[a]};
      // bytes above the read must survive an in-place store, or it went to the wrong address
      v = {i_mem.mem[a + 16'(sz + 1)], i_mem.mem[a + 16'(sz)]};
      ld(4'h9, a);
      exec(8'h12 + 8'(j), 4'h9, 4'h9, 16'h0000,
        {d == 0, j[0] ? d[7] : d[15], fl[1], 1'b0});
      rf[9] = j < 2 ? d + 16'(sz) : j < 4 ? a + 16'(sz) : a + 16'(2 * sz);
      chk_reg(4'h9);
      o = j >= 4 ? sz : 0;
      if (j >= 2)
        chk_val(j[0] ? {8'h00, i_mem.mem[a + 16'(o)]} :
          {i_mem.mem[a + 16'(o + 1)], i_mem.mem[a + 16'(o)]}, d, "stored");
      if (j == 2 || j == 3)
        chk_val({i_mem.mem[a + 16'(sz + 1)], i_mem.mem[a + 16'(sz)]}, v, "beside");
    end
    give_verdict();
  end
endmodule
